// ===== rtc_prescaler_shadow_alarm.sv
// real-time clock core: prescalers, shadow copies, alarm, backups and registers
//
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
//
// Contract
// - BCD calendar fields, binary subsecond count
// - calendar clock from three selectable sources
// - seven-bit async then fifteen-bit sync prescaler
// - tick rates divide by divider plus one
// - subsecond counts down, reloads at zero
// - second tick advances calendar with carries
// - bypass resets zero; then reads return shadows
// - shadow refresh every two clocks sets flag
// - no refresh in low power; software resyncs
// - system reset restores shadow defaults
// - enabled alarm flags when all fields match
// - masked alarm field always counts as match
// - all masked: flag three clocks after enable
// - five backup words, cleared on tamper
// - output pin: 512Hz, 1Hz or alarm
// - bypass holds sync flag low, reads live
module rtc_prescaler_shadow_alarm (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic bkp_rst_i,
  input wire logic low_speed_crystal_i,
  input wire logic internal_slow_oscillator_i,
  input wire logic high_speed_crystal_i,
  input wire logic tamper_i,
  input wire logic low_power_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output logic calendar_out_o,
  output logic alarm_flag_o
);
  rtc_core_if core_bus ();

  // backup-domain state
  logic [7:0] ctl_q, ctl_d;             // control bits
  logic [6:0] async_div_q, async_div_d; // async divider setting
  logic [14:0] sync_div_q, sync_div_d;  // sync divider setting
  logic [31:0] alarm_q, alarm_d;        // alarm time, day and masks
  logic [31:0] alarm_ss_q, alarm_ss_d;  // alarm subsecond and its mask
  logic [6:0] async_cnt_q, async_cnt_d; // async prescaler count
  logic [14:0] sub_q, sub_d;            // subsecond down counter
  logic [31:0] backup_q [rtc_pkg::BACKUP_COUNT];
  // system-domain state
  logic [31:0] sh_time_q, sh_time_d;    // shadow time
  logic [31:0] sh_date_q, sh_date_d;    // shadow date
  logic [14:0] sh_sub_q, sh_sub_d;      // shadow subsecond
  logic phase_q, phase_d;               // which calendar clock of the pair
  logic sync_flag_q, sync_flag_d;
  logic alarm_flag_q, alarm_flag_d;
  logic [1:0] en_cnt_q, en_cnt_d;       // calendar clocks since alarm enable
  logic [31:0] rdata_q, rdata_d;
  logic cal_out_q, cal_out_d;
  // tamper synchroniser
  logic tmp1_q, tmp2_q, tmp3_q, tmp_filt_q, tmp_filt_d;
  // decode and helpers
  logic bypass_w, alarm_en_w, async_tick_w, second_tick_w, refresh_w;
  logic tamper_w, stat_wr_w, match_w;

  rtc_clock_select u_clock_select (
    .clock_i(clock_i),
    .bkp_rst_i(bkp_rst_i),
    .low_speed_crystal_i(low_speed_crystal_i),
    .internal_slow_oscillator_i(internal_slow_oscillator_i),
    .high_speed_crystal_i(high_speed_crystal_i),
    .bus(core_bus.src)
  );

  rtc_bcd_calendar u_calendar (
    .clock_i(clock_i),
    .bkp_rst_i(bkp_rst_i),
    .bus(core_bus.cal)
  );

  assign bypass_w = ctl_q[rtc_pkg::CTL_BYPASS_BIT];
  assign alarm_en_w = ctl_q[rtc_pkg::CTL_ALARM_EN_BIT];
  assign stat_wr_w = wr_i && (addr_i == rtc_pkg::OFS_STAT);

  // async stage wraps after divider plus one calendar clocks
  assign async_tick_w = core_bus.rtc_edge && (async_cnt_q == async_div_q);
  // second when the subsecond counter is found at zero
  assign second_tick_w = async_tick_w && (sub_q == 15'h0000);

  assign core_bus.src_sel = ctl_q[rtc_pkg::CTL_SRC_LSB +: 2];
  assign core_bus.second_tick = second_tick_w;
  assign core_bus.load_time = wr_i && (addr_i == rtc_pkg::OFS_TIME);
  assign core_bus.load_date = wr_i && (addr_i == rtc_pkg::OFS_DATE);
  assign core_bus.load_data = wdata_i;

  // prescalers and settings; backup reset only
  always_comb
  begin
    ctl_d = ctl_q;
    async_div_d = async_div_q;
    sync_div_d = sync_div_q;
    alarm_d = alarm_q;
    alarm_ss_d = alarm_ss_q;
    async_cnt_d = async_cnt_q;
    sub_d = sub_q;
    if (core_bus.rtc_edge)
      async_cnt_d = async_tick_w ? 7'h00 : async_cnt_q + 7'h01;
    if (async_tick_w)
      sub_d = (sub_q == 15'h0000) ? sync_div_q : sub_q - 15'h0001;
    if (wr_i)
    begin
      case (addr_i)
        rtc_pkg::OFS_CTL: ctl_d = wdata_i[7:0];
        rtc_pkg::OFS_PSC:
        begin
          async_div_d = wdata_i[rtc_pkg::PSC_ASYNC_LSB +: 7];
          sync_div_d = wdata_i[14:0];
        end
        rtc_pkg::OFS_ALARM: alarm_d = wdata_i;
        rtc_pkg::OFS_ALARM_SS: alarm_ss_d = wdata_i;
        default: ; // other offsets hold no setting here
      endcase
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (bkp_rst_i)
    begin
      ctl_q <= rtc_pkg::CTL_RST;
      async_div_q <= rtc_pkg::ASYNC_DIV_RST;
      sync_div_q <= rtc_pkg::SYNC_DIV_RST;
      alarm_q <= rtc_pkg::ALARM_RST;
      alarm_ss_q <= rtc_pkg::ALARM_RST;
      async_cnt_q <= 7'h00;
      sub_q <= rtc_pkg::SYNC_DIV_RST;
    end
    else
    begin
      ctl_q <= ctl_d;
      async_div_q <= async_div_d;
      sync_div_q <= sync_div_d;
      alarm_q <= alarm_d;
      alarm_ss_q <= alarm_ss_d;
      async_cnt_q <= async_cnt_d;
      sub_q <= sub_d;
    end
  end

  // tamper pin: three-flop filter
  always_comb
  begin
    tmp_filt_d = (tmp2_q == tmp3_q) ? tmp3_q : tmp_filt_q;
  end

  always_ff @(posedge clock_i)
  begin
    if (bkp_rst_i)
    begin
      tmp1_q <= 1'b0;
      tmp2_q <= 1'b0;
      tmp3_q <= 1'b0;
      tmp_filt_q <= 1'b0;
    end
    else
    begin
      tmp1_q <= tamper_i;
      tmp2_q <= tmp1_q;
      tmp3_q <= tmp2_q;
      tmp_filt_q <= tmp_filt_d;
    end
  end

  assign tamper_w = tmp_filt_d & ~tmp_filt_q;

  // backups survive system reset; tamper beats a write
  genvar b;
  generate
    for (b = 0; b < rtc_pkg::BACKUP_COUNT; b++)
    begin : g_backup
      logic [31:0] bk_d;
      always_comb
      begin
        bk_d = backup_q[b];
        if (wr_i && addr_i == rtc_pkg::OFS_BACKUP0 + 8'(4 * b))
          bk_d = wdata_i;
        if (tamper_w)
          bk_d = 32'h0000_0000;
      end
      always_ff @(posedge clock_i)
      begin
        if (bkp_rst_i)
          backup_q[b] <= 32'h0000_0000;
        else
          backup_q[b] <= bk_d;
      end
    end
  endgenerate

  // refresh every second calendar clock unless low power or bypass
  assign refresh_w = core_bus.rtc_edge && (phase_q == rtc_pkg::SHADOW_PHASE_LAST)
                     && !low_power_i && !bypass_w;

  // a masked field matches whatever the calendar holds
  assign match_w =
    (alarm_q[rtc_pkg::ALM_SEC_MASK_BIT] || alarm_q[6:0] == core_bus.time_val[6:0]) &&
    (alarm_q[rtc_pkg::ALM_MIN_MASK_BIT] || alarm_q[14:8] == core_bus.time_val[14:8]) &&
    (alarm_q[rtc_pkg::ALM_HR_MASK_BIT] || alarm_q[21:16] == core_bus.time_val[21:16]) &&
    (alarm_q[rtc_pkg::ALM_DAY_MASK_BIT] || alarm_q[29:24] == core_bus.date_val[5:0]) &&
    (alarm_ss_q[rtc_pkg::ALM_SS_MASK_BIT] || alarm_ss_q[14:0] == sub_q);

  // shadows, flags, alarm delay, read data; system reset
  always_comb
  begin
    sh_time_d = sh_time_q;
    sh_date_d = sh_date_q;
    sh_sub_d = sh_sub_q;
    phase_d = core_bus.rtc_edge ? ~phase_q : phase_q;
    sync_flag_d = sync_flag_q;
    alarm_flag_d = alarm_flag_q;
    en_cnt_d = en_cnt_q;
    // write zero clears; hardware set below wins
    if (stat_wr_w && !wdata_i[rtc_pkg::STAT_SYNC_BIT])
      sync_flag_d = 1'b0;
    if (stat_wr_w && !wdata_i[rtc_pkg::STAT_ALARM_BIT])
      alarm_flag_d = 1'b0;
    if (refresh_w)
    begin
      sh_time_d = core_bus.time_val;
      sh_date_d = core_bus.date_val;
      sh_sub_d = sub_q;
      sync_flag_d = 1'b1;
    end
    if (bypass_w)
      sync_flag_d = 1'b0;
    // compare trusted after three enabled calendar clocks
    if (!alarm_en_w)
      en_cnt_d = 2'd0;
    else if (core_bus.rtc_edge && en_cnt_q != rtc_pkg::ALARM_EN_LATENCY)
      en_cnt_d = en_cnt_q + 2'd1;
    if (alarm_en_w && en_cnt_q == rtc_pkg::ALARM_EN_LATENCY && match_w)
      alarm_flag_d = 1'b1;
    // read data stand only in the cycle after the strobe
    rdata_d = 32'h0000_0000;
    if (rd_i)
    begin
      case (addr_i)
        rtc_pkg::OFS_TIME: rdata_d = bypass_w ? core_bus.time_val : sh_time_q;
        rtc_pkg::OFS_DATE: rdata_d = bypass_w ? core_bus.date_val : sh_date_q;
        rtc_pkg::OFS_SUBSEC: rdata_d = {17'h00000, bypass_w ? sub_q : sh_sub_q};
        rtc_pkg::OFS_CTL: rdata_d = {24'h000000, ctl_q};
        rtc_pkg::OFS_STAT: rdata_d = {30'h00000000, alarm_flag_q, sync_flag_q};
        rtc_pkg::OFS_PSC: rdata_d = {9'h000, async_div_q, 1'b0, sync_div_q};
        rtc_pkg::OFS_ALARM: rdata_d = alarm_q;
        rtc_pkg::OFS_ALARM_SS: rdata_d = alarm_ss_q;
        default:
        begin
          rdata_d = 32'h0000_0000; // unmapped offsets read zero
          for (int k = 0; k < rtc_pkg::BACKUP_COUNT; k++)
            if (addr_i == rtc_pkg::OFS_BACKUP0 + 8'(4 * k))
              rdata_d = backup_q[k];
        end
      endcase
    end
    // output pin selection; alarm level follows the polarity bit
    case (rtc_pkg::out_sel_type'(ctl_q[rtc_pkg::CTL_OUT_LSB +: 2]))
      rtc_pkg::OUT_512HZ: cal_out_d = async_cnt_q[rtc_pkg::OUT_512HZ_BIT];
      rtc_pkg::OUT_1HZ: cal_out_d = sub_q[rtc_pkg::OUT_1HZ_BIT];
      rtc_pkg::OUT_ALARM: cal_out_d = alarm_flag_q ^ ctl_q[rtc_pkg::CTL_POL_BIT];
      default: cal_out_d = 1'b0;
    endcase
  end

  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      sh_time_q <= rtc_pkg::TIME_RST;
      sh_date_q <= rtc_pkg::DATE_RST;
      sh_sub_q <= rtc_pkg::SYNC_DIV_RST;
      phase_q <= 1'b0;
      sync_flag_q <= 1'b0;
      alarm_flag_q <= 1'b0;
      en_cnt_q <= 2'd0;
      rdata_q <= 32'h0000_0000;
      cal_out_q <= 1'b0;
    end
    else
    begin
      sh_time_q <= sh_time_d;
      sh_date_q <= sh_date_d;
      sh_sub_q <= sh_sub_d;
      phase_q <= phase_d;
      sync_flag_q <= sync_flag_d;
      alarm_flag_q <= alarm_flag_d;
      en_cnt_q <= en_cnt_d;
      rdata_q <= rdata_d;
      cal_out_q <= cal_out_d;
    end
  end

  assign rdata_o = rdata_q;
  assign calendar_out_o = cal_out_q;
  assign alarm_flag_o = alarm_flag_q;
endmodule

// ===== rtc_pkg.sv
// shared constants for the real-time clock core
package rtc_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_TIME = 8'h00;
  localparam logic [7:0] OFS_DATE = 8'h04;
  localparam logic [7:0] OFS_CTL = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0c;
  localparam logic [7:0] OFS_PSC = 8'h10;
  localparam logic [7:0] OFS_ALARM = 8'h14;
  localparam logic [7:0] OFS_ALARM_SS = 8'h18;
  localparam logic [7:0] OFS_SUBSEC = 8'h1c;
  localparam logic [7:0] OFS_BACKUP0 = 8'h20;
  localparam int BACKUP_COUNT = 5;
  // control fields
  localparam int CTL_BYPASS_BIT = 0;
  localparam int CTL_ALARM_EN_BIT = 1;
  localparam int CTL_SRC_LSB = 2;
  localparam int CTL_OUT_LSB = 4;
  localparam int CTL_POL_BIT = 6;
  localparam logic [7:0] CTL_RST = 8'h00;
  // status fields
  localparam int STAT_SYNC_BIT = 0;
  localparam int STAT_ALARM_BIT = 1;
  // prescaler fields and reset values
  localparam int PSC_ASYNC_LSB = 16;
  localparam logic [6:0] ASYNC_DIV_RST = 7'h7f;
  localparam logic [14:0] SYNC_DIV_RST = 15'h00ff;
  // alarm mask bit positions
  localparam int ALM_SEC_MASK_BIT = 7;
  localparam int ALM_MIN_MASK_BIT = 15;
  localparam int ALM_HR_MASK_BIT = 23;
  localparam int ALM_DAY_MASK_BIT = 31;
  localparam int ALM_SS_MASK_BIT = 31;
  localparam logic [31:0] ALARM_RST = 32'h0000_0000;
  // calendar reset values, BCD
  localparam logic [31:0] TIME_RST = 32'h0000_0000;
  localparam logic [31:0] DATE_RST = 32'h0000_2101;
  // high-speed crystal divide ratio and counter width
  localparam int HS_DIV = 32;
  localparam int HS_DIV_W = 5;
  // phase of the calendar clock pair on which the shadows refresh
  localparam logic [0:0] SHADOW_PHASE_LAST = 1'b1;
  // calendar clocks from alarm enable to first possible flag
  localparam logic [1:0] ALARM_EN_LATENCY = 2'd3;
  // taps on the prescaler counters for the square-wave output
  localparam int OUT_512HZ_BIT = 5;
  localparam int OUT_1HZ_BIT = 7;
  typedef enum logic [1:0] {SRC_LOW_SPEED, SRC_INTERNAL_SLOW, SRC_HIGH_SPEED_DIV} src_type;
  typedef enum logic [1:0] {OUT_OFF, OUT_512HZ, OUT_1HZ, OUT_ALARM} out_sel_type;
endpackage

// ===== rtc_core_if.sv
// signals shared between the core, the clock selector and the calendar counter
`timescale 1ns/100ps
interface rtc_core_if;
  logic [1:0] src_sel;      // selected calendar clock source
  logic rtc_edge;           // one pulse per calendar clock cycle
  logic second_tick;        // one pulse per second
  logic load_time;          // software writes the time register
  logic load_date;          // software writes the date register
  logic [31:0] load_data;   // value written
  logic [31:0] time_val;    // live time, BCD
  logic [31:0] date_val;    // live date, BCD
  modport src (input src_sel, output rtc_edge);
  modport cal (input second_tick, load_time, load_date, load_data, output time_val, date_val);
  modport core (output src_sel, second_tick, load_time, load_date, load_data,
                input rtc_edge, time_val, date_val);
endinterface

// ===== rtc_clock_select.sv
// synchronises three slow clock pins, picks the calendar clock
`timescale 1ns/100ps
module rtc_clock_select (
  input wire logic clock_i,
  input wire logic bkp_rst_i,
  input wire logic low_speed_crystal_i,
  input wire logic internal_slow_oscillator_i,
  input wire logic high_speed_crystal_i,
  rtc_core_if.src bus
);
  logic [2:0] pin_w;              // raw pins
  logic [2:0] s1_q, s2_q, s3_q;   // three-stage synchroniser
  logic [2:0] filt_q, filt_d;     // accepted level
  logic [2:0] rise_w;             // accepted rising edges
  localparam int HS_DIV_W = rtc_pkg::HS_DIV_W;
  logic [HS_DIV_W-1:0] hs_q, hs_d; // divider on the high-speed crystal
  logic hs_edge_w;
  logic edge_q, edge_d;

  assign pin_w = {high_speed_crystal_i, internal_slow_oscillator_i, low_speed_crystal_i};

  // per source: a level counts only once stages two and three agree
  genvar i;
  generate
    for (i = 0; i < 3; i++)
    begin : g_src
      always_comb
      begin
        filt_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : filt_q[i];
      end
      always_ff @(posedge clock_i)
      begin
        if (bkp_rst_i)
        begin
          s1_q[i] <= 1'b0;
          s2_q[i] <= 1'b0;
          s3_q[i] <= 1'b0;
          filt_q[i] <= 1'b0;
        end
        else
        begin
          s1_q[i] <= pin_w[i];
          s2_q[i] <= s1_q[i];
          s3_q[i] <= s2_q[i];
          filt_q[i] <= filt_d[i];
        end
      end
      assign rise_w[i] = filt_d[i] & ~filt_q[i];
    end
  endgenerate

  // divide the high-speed crystal and choose the source
  always_comb
  begin
    hs_d = hs_q;
    if (rise_w[2])
      hs_d = hs_q + HS_DIV_W'(1); // wraps at the divide ratio
    hs_edge_w = rise_w[2] && (hs_q == HS_DIV_W'(rtc_pkg::HS_DIV - 1));
    case (rtc_pkg::src_type'(bus.src_sel))
      rtc_pkg::SRC_LOW_SPEED: edge_d = rise_w[0];
      rtc_pkg::SRC_INTERNAL_SLOW: edge_d = rise_w[1];
      rtc_pkg::SRC_HIGH_SPEED_DIV: edge_d = hs_edge_w;
      default: edge_d = 1'b0; // unused code stops the calendar clock
    endcase
  end

  always_ff @(posedge clock_i)
  begin
    if (bkp_rst_i)
    begin
      hs_q <= '0;
      edge_q <= 1'b0;
    end
    else
    begin
      hs_q <= hs_d;
      edge_q <= edge_d;
    end
  end

  assign bus.rtc_edge = edge_q;
endmodule

// ===== rtc_bcd_calendar.sv
// live BCD time and date counter advanced by the second tick
`timescale 1ns/100ps
module rtc_bcd_calendar (
  input wire logic clock_i,
  input wire logic bkp_rst_i,
  rtc_core_if.cal bus
);
  logic [6:0] sec_q, sec_d, min_q, min_d; // BCD seconds and minutes
  logic [5:0] hr_q, hr_d;                 // BCD hours, 24-hour
  logic [2:0] wd_q, wd_d;                 // weekday 1..7
  logic [5:0] day_q, day_d;               // BCD day of month
  logic [4:0] mon_q, mon_d;               // BCD month
  logic [7:0] yr_q, yr_d;                 // BCD year 00..99
  logic [5:0] dim_w;                      // last day of this month, BCD
  logic leap_w;

  // add one to a two-digit BCD value
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
  endfunction

  // year divisible by four, judged from the BCD digits
  assign leap_w = yr_q[4] ? (yr_q[3:0] == 4'h2 || yr_q[3:0] == 4'h6)
                          : (yr_q[3:0] == 4'h0 || yr_q[3:0] == 4'h4 || yr_q[3:0] == 4'h8);

  always_comb
  begin
    case (mon_q)
      5'h02: dim_w = leap_w ? 6'h29 : 6'h28;
      5'h04, 5'h06, 5'h09, 5'h11: dim_w = 6'h30;
      default: dim_w = 6'h31;
    endcase
  end

  // software load first, else one second with carries
  always_comb
  begin
    {sec_d, min_d, hr_d, wd_d, day_d, mon_d, yr_d} = {sec_q, min_q, hr_q, wd_q, day_q, mon_q, yr_q};
    if (bus.load_time)
    begin
      sec_d = bus.load_data[6:0];
      min_d = bus.load_data[14:8];
      hr_d = bus.load_data[21:16];
    end
    else if (bus.load_date)
    begin
      day_d = bus.load_data[5:0];
      mon_d = bus.load_data[12:8];
      wd_d = bus.load_data[15:13];
      yr_d = bus.load_data[23:16];
    end
    else if (bus.second_tick)
    begin
      sec_d = 7'(bcd_inc({1'b0, sec_q}));
      if (sec_q == 7'h59)
      begin
        sec_d = 7'h00;
        min_d = 7'(bcd_inc({1'b0, min_q}));
        if (min_q == 7'h59)
        begin
          min_d = 7'h00;
          hr_d = 6'(bcd_inc({2'b00, hr_q}));
          if (hr_q == 6'h23)
          begin
            hr_d = 6'h00;
            wd_d = (wd_q == 3'd7) ? 3'd1 : wd_q + 3'd1;
            day_d = 6'(bcd_inc({2'b00, day_q}));
            if (day_q == dim_w)
            begin
              day_d = 6'h01;
              mon_d = 5'(bcd_inc({3'b000, mon_q}));
              if (mon_q == 5'h12)
              begin
                mon_d = 5'h01;
                yr_d = (yr_q == 8'h99) ? 8'h00 : bcd_inc(yr_q);
              end
            end
          end
        end
      end
    end
  end

  // only the backup-domain reset touches the live calendar
  always_ff @(posedge clock_i)
  begin
    if (bkp_rst_i)
    begin
      sec_q <= rtc_pkg::TIME_RST[6:0];
      min_q <= rtc_pkg::TIME_RST[14:8];
      hr_q <= rtc_pkg::TIME_RST[21:16];
      day_q <= rtc_pkg::DATE_RST[5:0];
      mon_q <= rtc_pkg::DATE_RST[12:8];
      wd_q <= rtc_pkg::DATE_RST[15:13];
      yr_q <= rtc_pkg::DATE_RST[23:16];
    end
    else
    begin
      {sec_q, min_q, hr_q, wd_q, day_q, mon_q, yr_q} <= {sec_d, min_d, hr_d, wd_d, day_d, mon_d, yr_d};
    end
  end

  assign bus.time_val = {10'h000, hr_q, 1'b0, min_q, 1'b0, sec_q};
  assign bus.date_val = {8'h00, yr_q, wd_q, mon_q, 2'b00, day_q};
endmodule

// ===== rtc_prescaler_shadow_alarm_properties.sv
// port-level assertions for the real-time clock core
`timescale 1ns/100ps
module rtc_prescaler_shadow_alarm_properties (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic bkp_rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic calendar_out_o,
  input wire logic alarm_flag_o
);
  logic [6:0] ctl_q; // control mirror; system reset leaves it alone
  logic [6:0] ctl_d; // next mirror value
  logic clr; // alarm flag clear
  assign clr = wr_i && addr_i == rtc_pkg::OFS_STAT && !wdata_i[1];
  // mirror control writes
  always_comb
    ctl_d = (wr_i && addr_i == rtc_pkg::OFS_CTL) ? wdata_i[6:0] : ctl_q;
  always_ff @(posedge clock_i)
    ctl_q <= bkp_rst_i ? 7'h00 : ctl_d;
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i || bkp_rst_i);
  AST_RST_OUTS:
    assert property (disable iff (bkp_rst_i) sys_rst_i |=> rdata_o == 32'h0
      && !alarm_flag_o && !calendar_out_o) else $error("outputs not cleared by reset");
  AST_RD_IDLE:
    assert property (!rd_i |=> rdata_o == 32'h0) else $error("read data without a read");
  AST_UNMAPPED:
    assert property (rd_i && addr_i > 8'h30 |=> rdata_o == 32'h0)
      else $error("unmapped read not zero");
  AST_TIME_BCD:
    assert property (rd_i && addr_i == rtc_pkg::OFS_TIME |=> rdata_o[3:0] < 4'ha
      && rdata_o[11:8] < 4'ha && rdata_o[19:16] < 4'ha && rdata_o[31:22] == 10'h0)
      else $error("time digit out of range");
  AST_BYPASS_SYNC:
    assert property (rd_i && addr_i == rtc_pkg::OFS_STAT && ctl_q[0] && $past(ctl_q[0], 2)
      |=> !rdata_o[0]) else $error("sync flag set while bypassed");
  AST_ALARM_EN:
    assert property ($rose(alarm_flag_o) |-> $past(ctl_q[1]) || $past(ctl_q[1], 2))
      else $error("alarm flag rose while disabled");
  AST_ALARM_STICKY:
    assert property ($fell(alarm_flag_o) |-> $past(clr) || $past(clr, 2))
      else $error("alarm flag dropped by itself");
  AST_OUT_OFF:
    assert property (ctl_q[5:4] == 2'h0 && $past(ctl_q[5:4]) == 2'h0 |-> !calendar_out_o)
      else $error("output pin active while off");
  AST_OUT_ALARM:
    assert property (ctl_q[5:4] == 2'h3 && $stable(ctl_q) && $past(ctl_q, 2) == ctl_q
      && $stable(alarm_flag_o) && $past(alarm_flag_o, 2) == alarm_flag_o && !$past(sys_rst_i)
      && !$past(sys_rst_i, 2) |-> calendar_out_o == (alarm_flag_o ^ ctl_q[6]))
      else $error("output pin disagrees with alarm");
  cover property ($rose(alarm_flag_o));
  cover property (rd_i && addr_i == rtc_pkg::OFS_TIME);
  cover property ($rose(calendar_out_o));
endmodule
bind rtc_prescaler_shadow_alarm rtc_prescaler_shadow_alarm_properties
  i_rtc_prescaler_shadow_alarm_properties (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
  .bkp_rst_i(bkp_rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .calendar_out_o(calendar_out_o), .alarm_flag_o(alarm_flag_o));

// ===== tb_rtc_prescaler_shadow_alarm.sv
// self-checking bench for the real-time clock core
`timescale 1ns/100ps
module tb_rtc_prescaler_shadow_alarm;
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic bkp_rst_i = 1'b1;
  logic lsx = 1'b0; // 20-clock period
  logic irc = 1'b0; // 24-clock period
  logic hsx = 1'b0; // 4-clock period, /32 inside
  logic tamper_i = 1'b0;
  logic low_power_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic calendar_out_o;
  logic alarm_flag_o;
  logic [31:0] v; // last read value
  int fail_count = 0;
  int comparisons = 0;
  int cyc = 0; // clock count
  int t0;
  int n;
  int per[3] = '{20, 24, 128}; // calendar period per source
  logic [7:0] ra[6] = '{rtc_pkg::OFS_TIME, rtc_pkg::OFS_DATE, rtc_pkg::OFS_SUBSEC,
    rtc_pkg::OFS_PSC, rtc_pkg::OFS_CTL, 8'h34};
  logic [31:0] re[6] = '{rtc_pkg::TIME_RST, rtc_pkg::DATE_RST, {17'h0, rtc_pkg::SYNC_DIV_RST},
    {9'h0, rtc_pkg::ASYNC_DIV_RST, 1'b0, rtc_pkg::SYNC_DIV_RST}, {24'h0, rtc_pkg::CTL_RST}, 32'h0};
  rtc_prescaler_shadow_alarm i_rtc_prescaler_shadow_alarm (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .bkp_rst_i(bkp_rst_i),
    .low_speed_crystal_i(lsx), .internal_slow_oscillator_i(irc),
    .high_speed_crystal_i(hsx), .tamper_i(tamper_i), .low_power_i(low_power_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .calendar_out_o(calendar_out_o), .alarm_flag_o(alarm_flag_o));
  initial
    forever #2 clock_i = ~clock_i;
  // slow sources run free, kept at a quarter of the bus clock or slower
  always @(posedge clock_i)
  begin
    cyc <= cyc + 1;
    lsx <= (cyc % 20) < 10;
    irc <= (cyc % 24) < 12;
    hsx <= (cyc % 4) < 2;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  // data taken mid-cycle
  task automatic rd(input logic [7:0] a);
    @(posedge clock_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clock_i);
    rd_i <= 1'b0;
    @(negedge clock_i);
    v = rdata_o;
  endtask
  task automatic reset_reads(input int cnt);
    for (int i = 0; i < cnt; i++)
    begin
      rd(ra[i]);
      check(v, re[i]);
    end
  endtask
  // poll time until it moves
  task automatic next_second(input int lim);
    logic [31:0] old;
    rd(rtc_pkg::OFS_TIME);
    old = v;
    n = 0;
    while (v === old && n < lim)
    begin
      rd(rtc_pkg::OFS_TIME);
      n++;
    end
    check(32'(n < lim), 32'h1);
  endtask
  task automatic wait_sync();
    n = 0;
    do
    begin
      rd(rtc_pkg::OFS_STAT);
      n++;
    end
    while (v[0] !== 1'b1 && n < 40);
  endtask
  task automatic results();
    if (fail_count == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (60000) @(posedge clock_i);
    fail_count++;
    results();
  end
  initial
  begin
    repeat (5) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    bkp_rst_i <= 1'b0;
    reset_reads(6);
    // 512 Hz tap toggles every 32 calendar clocks by default
    wr(rtc_pkg::OFS_CTL, 32'h10);
    n = 0;
    v[0] = calendar_out_o;
    repeat (2000)
    begin
      @(negedge clock_i);
      n += int'(calendar_out_o !== v[0]);
      v[0] = calendar_out_o;
    end
    check(32'(n >= 3 && n <= 4), 32'h1);
    wr(rtc_pkg::OFS_CTL, 32'h0);
    wr(rtc_pkg::OFS_STAT, 32'h0);
    wait_sync();
    check(v[0], 1'b1);
    @(posedge clock_i);
    low_power_i <= 1'b1;
    wr(rtc_pkg::OFS_STAT, 32'h0);
    repeat (100) @(posedge clock_i);
    rd(rtc_pkg::OFS_STAT);
    check(v[0], 1'b0);
    @(posedge clock_i);
    low_power_i <= 1'b0;
    wait_sync();
    check(v[0], 1'b1);
    // fast dividers, live reads
    wr(rtc_pkg::OFS_PSC, 32'h0001_0004);
    wr(rtc_pkg::OFS_CTL, 32'h1);
    wr(rtc_pkg::OFS_STAT, 32'h0);
    repeat (60) @(posedge clock_i);
    rd(rtc_pkg::OFS_STAT);
    check(v[0], 1'b0);
    wr(rtc_pkg::OFS_DATE, 32'h0025_7231);
    wr(rtc_pkg::OFS_TIME, 32'h0023_5959);
    next_second(8000);
    check(v, 32'h0);
    rd(rtc_pkg::OFS_DATE);
    check(v, 32'h0026_8101);
    rd(rtc_pkg::OFS_SUBSEC);
    check(32'(v <= 32'h4), 32'h1);
    // a second is ten calendar clocks
    for (int s = 0; s < 3; s++)
    begin
      wr(rtc_pkg::OFS_CTL, 32'h1 | 32'(s << 2));
      next_second(2000);
      t0 = cyc;
      next_second(2000);
      check((cyc - t0 + per[s] / 2) / per[s], 32'd10);
    end
    wr(rtc_pkg::OFS_CTL, 32'h1);
    wr(rtc_pkg::OFS_ALARM_SS, 32'h8000_0000);
    wr(rtc_pkg::OFS_ALARM, 32'h8080_8080);
    wr(rtc_pkg::OFS_CTL, 32'h3);
    n = 0;
    while (alarm_flag_o !== 1'b1 && n < 200)
    begin
      @(negedge clock_i);
      n++;
    end
    check(32'(n > 40 && n <= 70), 32'h1);
    wr(rtc_pkg::OFS_CTL, 32'h1);
    wr(rtc_pkg::OFS_STAT, 32'h0);
    rd(rtc_pkg::OFS_STAT);
    check(v[1], 1'b0);
    wr(rtc_pkg::OFS_TIME, 32'h0000_0010);
    wr(rtc_pkg::OFS_ALARM, 32'h8080_8045);
    wr(rtc_pkg::OFS_CTL, 32'h3);
    repeat (300) @(negedge clock_i);
    check(alarm_flag_o, 1'b0);
    wr(rtc_pkg::OFS_TIME, 32'h0000_0045);
    repeat (10) @(negedge clock_i);
    check(alarm_flag_o, 1'b1);
    repeat (400) @(negedge clock_i);
    check(alarm_flag_o, 1'b1);
    wr(rtc_pkg::OFS_CTL, 32'h33);
    repeat (4) @(negedge clock_i);
    check(calendar_out_o, 1'b1);
    wr(rtc_pkg::OFS_CTL, 32'h73);
    repeat (4) @(negedge clock_i);
    check(calendar_out_o, 1'b0);
    wr(rtc_pkg::OFS_CTL, 32'h23);
    repeat (4) @(negedge clock_i);
    check(calendar_out_o, 1'b0);
    for (int i = 0; i < rtc_pkg::BACKUP_COUNT; i++)
      wr(rtc_pkg::OFS_BACKUP0 + 8'(4 * i), 32'ha5a5_0000 + 32'(i));
    for (int i = 0; i < rtc_pkg::BACKUP_COUNT; i++)
    begin
      rd(rtc_pkg::OFS_BACKUP0 + 8'(4 * i));
      check(v, 32'ha5a5_0000 + 32'(i));
    end
    @(posedge clock_i);
    tamper_i <= 1'b1;
    repeat (5) @(posedge clock_i);
    tamper_i <= 1'b0;
    repeat (10) @(posedge clock_i);
    for (int i = 0; i < rtc_pkg::BACKUP_COUNT; i++)
    begin
      rd(rtc_pkg::OFS_BACKUP0 + 8'(4 * i));
      check(v, 32'h0);
    end
    // low power keeps shadow defaults visible
    wr(rtc_pkg::OFS_CTL, 32'h0);
    @(posedge clock_i);
    low_power_i <= 1'b1;
    sys_rst_i <= 1'b1;
    repeat (5) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    reset_reads(3);
    check(alarm_flag_o, 1'b0);
    results();
  end
endmodule
